// [include/lis_defines.svh]
`ifndef LIS_DEFINES_SVH
`define LIS_DEFINES_SVH

// ============================================================
// Timing
`define LIS_CLK_HZ        20000000
`define LIS_POWERUP_S     15
`define LIS_HOLDOFF_S     10
`define LIS_ORANGE_S      3
`define LIS_FLASH_OR_S    8
`define LIS_ERR_RED_S     2
`define LIS_IDLE_MS       100
`define LIS_BLINK_MS      300
`define LIS_DEB_MS        10

// ============================================================
// Register offsets
`define LIS_REG_CTRL      4'h0
`define LIS_REG_STATUS    4'h1
`define LIS_REG_ERR       4'h2

// ============================================================
// Fields
`define LIS_CTRL_W        4
`define LIS_CTRL_RST      4'h0
`define LIS_ERR_CLR_BIT   8
`define LIS_CODE_W        8
`define LIS_SEC_W         5

`endif

// [include/lis_pkg.sv]
package lis_pkg;

    typedef enum logic [1:0] {
        LIS_PICO_MODE             = 2'h0,
        LIS_NANO_MODE             = 2'h1,
        LIS_CONTINUOUS_WAVE_MODE  = 2'h2,
        LIS_SPARE_MODE            = 2'h3
    } lis_mode_t;

    typedef struct packed {
        logic      trig_ext;
        lis_mode_t mode;
        logic      soft_lock;
    } lis_ctrl_t;

    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } lis_rgb_t;

    typedef struct packed {
        logic on;
        logic bright;
    } lis_emit_led_t;

    typedef enum logic [3:0] {
        LIS_ST_ORANGE    = 4'h1,
        LIS_ST_FLASH_OR  = 4'h2,
        LIS_ST_FLASH_GR  = 4'h4,
        LIS_ST_GREEN     = 4'h8
    } lis_pwr_st_t;

endpackage : lis_pkg

// [rtl/lis_ctrl.sv]
// Contract
// - Status LED orange, flashing, then green 15s
// - Internal error: red over 2s, code readable
// - Mode LED blue, light blue, orange
// - Mode LED dark after 100 ms idle
// - Mode LED lit only with valid trigger
// - No supply: no emission, LED dark
// - Standby or open loop: blink dim white
// - Loop closed with key on: auto restart
// - Key on and loop closed: bright white
// - Standby key cuts laser source power
// - Open interlock loop cuts source power
// - Emission locked first 10 s
// - Emission off during hardware self-check
// - Abnormal condition locks emission immediately
// - Lost external trigger does not lock
// - Host soft lock keeps emission off
// - Gate qualifies internal and external trigger
// - Gate acts combinationally between pulses
// - Continuous wave follows gate level directly
// - No host: run stored nonvolatile parameters
// - Parameters change only over host port
// - Fans always run while powered
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "lis_defines.svh"

module lis_ctrl
    import lis_pkg::*;
#(
    parameter int SEC_CYC   = `LIS_CLK_HZ,
    parameter int DEB_CYC   = `LIS_DEB_MS * (`LIS_CLK_HZ / 1000),
    parameter int IDLE_CYC  = `LIS_IDLE_MS * (`LIS_CLK_HZ / 1000),
    parameter int BLINK_CYC = (`LIS_BLINK_MS * (`LIS_CLK_HZ / 1000)) / 2
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [3:0]             addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    input  wire logic                   key_on_i,
    input  wire logic                   ilk_closed_i,
    input  wire logic                   selfcheck_done_i,
    input  wire logic                   fault_i,
    input  wire logic [`LIS_CODE_W-1:0] fault_code_i,
    input  wire lis_ctrl_t              nvm_params_i,
    output logic                        nvm_store_o,
    output lis_ctrl_t                   nvm_data_o,
    input  wire logic                   int_trig_i,
    input  wire logic                   ext_trig_i,
    input  wire logic                   gate_i,
    output logic                        laser_emit_o,
    output logic                        src_pwr_en_o,
    output logic                        fan_on_o,
    output lis_rgb_t                    status_led_o,
    output lis_rgb_t                    mode_led_o,
    output lis_emit_led_t               emit_led_o
);

    localparam int CNT_W  = $clog2(SEC_CYC + 1);
    localparam int DEB_W  = $clog2(DEB_CYC + 1);
    localparam int IDLE_W = $clog2(IDLE_CYC + 1);
    localparam int BLK_W  = $clog2(BLINK_CYC + 1);
    localparam logic [`LIS_SEC_W-1:0] SEC_MAX  = '1;
    localparam logic [`LIS_SEC_W-1:0] S_HOLD   = `LIS_SEC_W'(`LIS_HOLDOFF_S);
    localparam logic [`LIS_SEC_W-1:0] S_UP     = `LIS_SEC_W'(`LIS_POWERUP_S);
    localparam logic [`LIS_SEC_W-1:0] S_OR     = `LIS_SEC_W'(`LIS_ORANGE_S);
    localparam logic [`LIS_SEC_W-1:0] S_FOR    = `LIS_SEC_W'(`LIS_FLASH_OR_S);
    localparam logic [`LIS_SEC_W-1:0] S_RED    = `LIS_SEC_W'(`LIS_ERR_RED_S + 1);

    // ============================================================
    // Key and interlock input conditioning
    logic [1:0] pin_raw;
    logic [1:0] db_r;
    logic       key_db;
    logic       ilk_db;
    logic       key_standby_position;

    assign pin_raw = {ilk_closed_i, key_on_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_deb
            logic             sync1_r;
            logic             sync2_r;
            logic             db_bit_r;
            logic [DEB_W-1:0] cnt_r;
            assign db_r[gi] = db_bit_r;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_r  <= 1'b0;
                    sync2_r  <= 1'b0;
                    db_bit_r <= 1'b0;
                    cnt_r    <= '0;
                end else begin
                    sync1_r <= pin_raw[gi];
                    sync2_r <= sync1_r;
                    if (sync2_r == db_bit_r) begin
                        cnt_r <= '0;
                    end else if (cnt_r == DEB_W'(DEB_CYC - 1)) begin
                        db_bit_r <= sync2_r;
                        cnt_r    <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign key_db               = db_r[0];
    assign ilk_db               = db_r[1];
    assign key_standby_position = ~key_db;

    // ============================================================
    // Seconds since power-up and blink divider
    logic [CNT_W-1:0]      div_r;
    logic                  sec_tick;
    logic [`LIS_SEC_W-1:0] sec_cnt_r;
    logic [BLK_W-1:0]      blk_cnt_r;
    logic                  blink_r;

    assign sec_tick = (div_r == CNT_W'(SEC_CYC - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r     <= '0;
            sec_cnt_r <= '0;
        end else begin
            div_r <= sec_tick ? '0 : div_r + 1'b1;
            if (sec_tick && sec_cnt_r != SEC_MAX) begin
                sec_cnt_r <= sec_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_cnt_r <= '0;
            blink_r   <= 1'b0;
        end else if (blk_cnt_r == BLK_W'(BLINK_CYC - 1)) begin
            blk_cnt_r <= '0;
            blink_r   <= ~blink_r;
        end else begin
            blk_cnt_r <= blk_cnt_r + 1'b1;
        end
    end

    // ============================================================
    // Power-up status sequence
    lis_pwr_st_t st_r;
    lis_pwr_st_t st_nxt;

    // Orange, flash orange, flash green, green
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            LIS_ST_ORANGE:   if (sec_cnt_r >= S_OR) st_nxt = LIS_ST_FLASH_OR;
            LIS_ST_FLASH_OR: if (sec_cnt_r >= S_FOR) st_nxt = LIS_ST_FLASH_GR;
            LIS_ST_FLASH_GR: if (sec_cnt_r >= S_UP) st_nxt = LIS_ST_GREEN;
            LIS_ST_GREEN:    st_nxt = LIS_ST_GREEN;
            default:         st_nxt = LIS_ST_ORANGE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= LIS_ST_ORANGE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Fault latch, error code, self-check
    logic                   fault_r;
    logic [`LIS_CODE_W-1:0] code_r;
    logic [`LIS_SEC_W-1:0]  red_sec_r;
    logic                   check_done_r;
    logic                   err_clr;
    logic                   red_on;

    assign err_clr = wr_i && (addr_i == `LIS_REG_ERR) && wdata_i[`LIS_ERR_CLR_BIT];
    assign red_on  = fault_r || (red_sec_r != '0);

    // Latch code; set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_r   <= 1'b0;
            code_r    <= '0;
            red_sec_r <= '0;
        end else begin
            if (fault_i) begin
                fault_r <= 1'b1;
                code_r  <= fault_code_i;
            end else if (err_clr) begin
                fault_r <= 1'b0;
            end
            if (fault_i && !fault_r) begin
                red_sec_r <= S_RED;
            end else if (sec_tick && red_sec_r != '0) begin
                red_sec_r <= red_sec_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            check_done_r <= 1'b0;
        end else if (selfcheck_done_i) begin
            check_done_r <= 1'b1;
        end
    end

    // ============================================================
    // Operating parameters
    lis_ctrl_t ctrl_r;
    logic      load_pend_r;
    logic      ctrl_wr;

    assign ctrl_wr = wr_i && (addr_i == `LIS_REG_CTRL);

    // Stored set loaded after reset release
    // Only the host port changes them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r      <= `LIS_CTRL_RST;
            load_pend_r <= 1'b1;
            nvm_store_o <= 1'b0;
            nvm_data_o  <= `LIS_CTRL_RST;
        end else begin
            load_pend_r <= 1'b0;
            nvm_store_o <= ctrl_wr;
            if (ctrl_wr) begin
                ctrl_r     <= lis_ctrl_t'(wdata_i[`LIS_CTRL_W-1:0]);
                nvm_data_o <= lis_ctrl_t'(wdata_i[`LIS_CTRL_W-1:0]);
            end else if (load_pend_r) begin
                ctrl_r <= nvm_params_i;
            end
        end
    end

    // ============================================================
    // Emission enable
    logic pwr_ok;
    logic holdoff_done;
    logic emit_ok;
    logic emit_en_r;
    logic is_cwm;
    logic sel_trig;

    assign pwr_ok       = key_db & ilk_db;
    assign src_pwr_en_o = pwr_ok;
    assign holdoff_done = (sec_cnt_r >= S_HOLD);
    // Trigger presence not part of lock
    assign emit_ok = pwr_ok & holdoff_done & check_done_r & ~fault_r & ~fault_i
                   & ~ctrl_r.soft_lock;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            emit_en_r <= 1'b0;
        end else begin
            emit_en_r <= emit_ok;
        end
    end

    assign is_cwm   = (ctrl_r.mode == LIS_CONTINUOUS_WAVE_MODE);
    assign sel_trig = ctrl_r.trig_ext ? ext_trig_i : int_trig_i;

    // Live fault blocks output at once
    // Continuous wave follows gate level
    // Source power gates output in the cycle the debounced key or loop input drops
    assign laser_emit_o = emit_en_r & pwr_ok & ~fault_i & gate_i & (is_cwm | sel_trig);

    assign fan_on_o = 1'b1;

    // ============================================================
    // Trigger activity
    logic              act_raw;
    logic              act_s1_r;
    logic              act_s2_r;
    logic              act_s3_r;
    logic              act_evt;
    logic [IDLE_W-1:0] idle_cnt_r;
    logic              trig_active;

    assign act_raw = gate_i & (is_cwm | sel_trig);
    assign act_evt = act_s2_r & ~act_s3_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_s1_r   <= 1'b0;
            act_s2_r   <= 1'b0;
            act_s3_r   <= 1'b0;
            idle_cnt_r <= IDLE_W'(IDLE_CYC);
        end else begin
            act_s1_r <= act_raw;
            act_s2_r <= act_s1_r;
            act_s3_r <= act_s2_r;
            if (act_evt) begin
                idle_cnt_r <= '0;
            end else if (idle_cnt_r != IDLE_W'(IDLE_CYC)) begin
                idle_cnt_r <= idle_cnt_r + 1'b1;
            end
        end
    end

    assign trig_active = (idle_cnt_r != IDLE_W'(IDLE_CYC));

    // ============================================================
    // Indicators
    lis_rgb_t      mode_col;
    lis_rgb_t      stat_col;
    lis_rgb_t      mode_led_r;
    lis_rgb_t      stat_led_r;
    lis_emit_led_t emit_led_r;
    lis_emit_led_t emit_col;

    assign mode_col = (ctrl_r.mode == LIS_PICO_MODE) ? 3'h1 :
                      (ctrl_r.mode == LIS_NANO_MODE) ? 3'h3 :
                      is_cwm                         ? 3'h6 : 3'h0;

    assign stat_col = red_on                    ? 3'h4 :
                      (st_r == LIS_ST_ORANGE)   ? 3'h6 :
                      (st_r == LIS_ST_FLASH_OR) ? (blink_r ? 3'h6 : 3'h0) :
                      (st_r == LIS_ST_FLASH_GR) ? (blink_r ? 3'h2 : 3'h0) : 3'h2;

    assign emit_col = emit_en_r ? 2'h3 : {blink_r, 1'b0};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_led_r <= '0;
            stat_led_r <= '0;
            emit_led_r <= '0;
        end else begin
            mode_led_r <= trig_active ? mode_col : 3'h0;
            stat_led_r <= stat_col;
            emit_led_r <= emit_col;
        end
    end

    assign mode_led_o   = mode_led_r;
    assign status_led_o = stat_led_r;
    assign emit_led_o   = emit_led_r;

    // ============================================================
    // Register read port
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign status_word = {25'h0, trig_active, emit_en_r, fault_r, check_done_r,
                          holdoff_done, ilk_db, key_db};
    assign rd_mux = (addr_i == `LIS_REG_CTRL)   ? {28'h0, ctrl_r} :
                    (addr_i == `LIS_REG_STATUS) ? status_word :
                    (addr_i == `LIS_REG_ERR)    ? {24'h0, code_r} : 32'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
        end
    end

    // ============================================================
    // Assertions
    property p_holdoff;
        @(posedge clk_i) disable iff (!rst_n_i)
        emit_en_r |-> sec_cnt_r >= S_HOLD;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("emission before hold-off");

    property p_key_pwr;
        @(posedge clk_i) disable iff (!rst_n_i)
        key_standby_position |-> !src_pwr_en_o && !laser_emit_o;
    endproperty
    a_key_pwr: assert property (p_key_pwr) else $error("power on in standby");

    property p_ilk_pwr;
        @(posedge clk_i) disable iff (!rst_n_i)
        !ilk_db |=> !emit_en_r;
    endproperty
    a_ilk_pwr: assert property (p_ilk_pwr) else $error("emission with open loop");

    property p_fault_now;
        @(posedge clk_i) disable iff (!rst_n_i)
        fault_i |-> !laser_emit_o ##1 !emit_en_r;
    endproperty
    a_fault_now: assert property (p_fault_now) else $error("fault did not lock");

    property p_soft;
        @(posedge clk_i) disable iff (!rst_n_i)
        ctrl_r.soft_lock |=> !emit_en_r;
    endproperty
    a_soft: assert property (p_soft) else $error("soft lock ignored");

    property p_restart;
        @(posedge clk_i) disable iff (!rst_n_i)
        emit_ok |=> emit_en_r ##1 emit_led_o == 2'h3;
    endproperty
    a_restart: assert property (p_restart) else $error("no automatic restart");

    property p_check;
        @(posedge clk_i) disable iff (!rst_n_i)
        !check_done_r |=> !emit_en_r;
    endproperty
    a_check: assert property (p_check) else $error("emission during self-check");

    property p_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        !trig_active |=> mode_led_o == 3'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("mode LED lit while idle");

    property p_cwm;
        @(posedge clk_i) disable iff (!rst_n_i)
        (is_cwm && emit_en_r && pwr_ok && !fault_i) |-> laser_emit_o == gate_i;
    endproperty
    a_cwm: assert property (p_cwm) else $error("output not following gate");

    property p_red;
        @(posedge clk_i) disable iff (!rst_n_i)
        (fault_i && !fault_r) |=> red_sec_r == S_RED ##1 status_led_o == 3'h4;
    endproperty
    a_red: assert property (p_red) else $error("red hold not started");

    property p_green;
        @(posedge clk_i) disable iff (!rst_n_i)
        st_r == LIS_ST_GREEN |-> sec_cnt_r >= S_UP;
    endproperty
    a_green: assert property (p_green) else $error("green too early");

    property p_fan;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(emit_en_r) |-> fan_on_o [*2];
    endproperty
    a_fan: assert property (p_fan) else $error("fan stopped");

endmodule : lis_ctrl

// [verification/lis_far_model.sv]
`timescale 1ns/1ps

module lis_far_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic key_cmd_i,
    input  wire logic ilk_cmd_i,
    input  wire logic osc_en_i,
    output logic      key_on_o,
    output logic      ilk_closed_o,
    output logic      int_trig_o
);
    // ==========
    // Contact bounce after each move
    logic [1:0] key_bnc_r;
    logic [1:0] ilk_bnc_r;
    logic       key_last_r;
    logic       ilk_last_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_bnc_r  <= 2'h0;
            ilk_bnc_r  <= 2'h0;
            key_last_r <= 1'b0;
            ilk_last_r <= 1'b0;
            int_trig_o <= 1'b0;
        end else begin
            key_last_r <= key_cmd_i;
            ilk_last_r <= ilk_cmd_i;
            key_bnc_r  <= (key_cmd_i != key_last_r) ? 2'h3 : key_bnc_r - {1'b0, |key_bnc_r};
            ilk_bnc_r  <= (ilk_cmd_i != ilk_last_r) ? 2'h3 : ilk_bnc_r - {1'b0, |ilk_bnc_r};
            // Oscillator still when disabled
            int_trig_o <= osc_en_i & ~int_trig_o;
        end
    end

    // One-cycle glitches, shorter than the debounce
    assign key_on_o     = key_cmd_i ^ key_bnc_r[0];
    assign ilk_closed_o = ilk_cmd_i ^ ilk_bnc_r[0];

endmodule : lis_far_model

// [verification/tb.sv]
`timescale 1ns/1ps

module tb;
    import lis_pkg::*;
    localparam int SEC = 20;
    localparam int DEB = 4;
    localparam int IDL = 50;
    localparam int BLK = 5;

    logic          clk_i            = 1'b0;
    logic          rst_n_i          = 1'b0;
    logic [3:0]    addr_i           = 4'h0;
    logic [31:0]   wdata_i          = 32'h0;
    logic          wr_i             = 1'b0;
    logic          rd_i             = 1'b0;
    logic          key_cmd          = 1'b0;
    logic          ilk_cmd          = 1'b0;
    logic          osc_en           = 1'b0;
    logic          selfcheck_done_i = 1'b0;
    logic          fault_i          = 1'b0;
    logic [7:0]    fault_code_i     = 8'h00;
    logic          ext_trig_i       = 1'b0;
    logic          gate_i           = 1'b0;
    lis_ctrl_t     nvm_params_i     = 4'h4;
    logic [31:0]   rdata_o;
    logic          key_on, ilk_closed, int_trig;
    logic          nvm_store_o, laser_emit_o, src_pwr_en_o, fan_on_o;
    lis_ctrl_t     nvm_data_o;
    lis_rgb_t      status_led_o, mode_led_o;
    lis_emit_led_t emit_led_o;
    int            err_count = 0;
    int            cmp_count = 0;
    int            cyc       = 0;

    always #25 clk_i = ~clk_i;

    lis_far_model lis_far_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .key_cmd_i(key_cmd),
        .ilk_cmd_i(ilk_cmd), .osc_en_i(osc_en), .key_on_o(key_on),
        .ilk_closed_o(ilk_closed), .int_trig_o(int_trig));

    lis_ctrl #(.SEC_CYC(SEC), .DEB_CYC(DEB), .IDLE_CYC(IDL), .BLINK_CYC(BLK)) lis_ctrl_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .key_on_i(key_on), .ilk_closed_i(ilk_closed),
        .selfcheck_done_i(selfcheck_done_i), .fault_i(fault_i), .fault_code_i(fault_code_i),
        .nvm_params_i(nvm_params_i), .nvm_store_o(nvm_store_o), .nvm_data_o(nvm_data_o),
        .int_trig_i(int_trig), .ext_trig_i(ext_trig_i), .gate_i(gate_i),
        .laser_emit_o(laser_emit_o), .src_pwr_en_o(src_pwr_en_o), .fan_on_o(fan_on_o),
        .status_led_o(status_led_o), .mode_led_o(mode_led_o), .emit_led_o(emit_led_o));

    // ==========
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wait_n

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    function automatic lis_rgb_t mode_exp(input lis_mode_t m);
        case (m)
            LIS_PICO_MODE:            return 3'h1;
            LIS_NANO_MODE:            return 3'h3;
            LIS_CONTINUOUS_WAVE_MODE: return 3'h6;
            default:                  return 3'h0;
        endcase
    endfunction : mode_exp

    function automatic logic emit_exp(input lis_mode_t m, input logic x, g, ti, te);
        return g & ((m == LIS_CONTINUOUS_WAVE_MODE) | (x ? te : ti));
    endfunction : emit_exp

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            close_out;
        end
    end

    // ==========
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [7:0]  code;
        logic        x, hi, lo;
        logic        exp_e;
        void'($urandom(31999));
        @(negedge clk_i);
        chk("fan_on_o", 32'h1, fan_on_o);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        key_cmd <= 1'b1;
        ilk_cmd <= 1'b1;
        osc_en  <= 1'b1;
        gate_i  <= 1'b1;
        rd(4'h0, v);
        chk("ctrl stored", 32'h4, v);
        wait_n(15);
        chk("status_led_o", 32'h6, status_led_o);
        wait_n(160);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        wait_n(50);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        @(posedge clk_i);
        selfcheck_done_i <= 1'b1;
        wait_n(140);
        chk("status_led_o", 32'h2, status_led_o);
        chk("emit_led_o", 32'h3, emit_led_o);
        chk("laser_emit_o", 32'h1, laser_emit_o);
        $display("test power-up done");

        for (int m = 3; m >= 0; m--) begin
            x = 1'($urandom_range(1));
            wr(4'h0, {28'h0, x, m[1:0], 1'b0});
            repeat (24) begin
                @(posedge clk_i);
                gate_i     <= 1'($urandom_range(1));
                ext_trig_i <= 1'($urandom_range(1));
                @(negedge clk_i);
                exp_e = emit_exp(lis_mode_t'(m[1:0]), x, gate_i, int_trig, ext_trig_i);
                chk("laser_emit_o", exp_e, laser_emit_o);
            end
            chk("mode_led_o", mode_exp(lis_mode_t'(m[1:0])), mode_led_o);
        end
        wr(4'h0, 32'h0);
        gate_i <= 1'b0;
        wait_n(IDL + 10);
        chk("mode_led_o idle", 32'h0, mode_led_o);
        @(posedge clk_i);
        gate_i <= 1'b1;
        wait_n(6);
        chk("mode_led_o relit", 32'h1, mode_led_o);
        wr(4'h0, 32'h8);
        ext_trig_i <= 1'b0;
        wait_n(IDL + 10);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        chk("mode_led_o", 32'h0, mode_led_o);
        rd(4'h1, v);
        chk("status", 32'h2F, v);
        $display("test trigger done");

        wr(4'h0, 32'h4);
        ilk_cmd <= 1'b0;
        wait_n(DEB + 12);
        chk("src_pwr_en_o", 32'h0, src_pwr_en_o);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        hi = 1'b0;
        lo = 1'b0;
        repeat (4 * BLK) begin
            @(negedge clk_i);
            hi = hi | emit_led_o.on;
            lo = lo | !emit_led_o.on;
        end
        chk("emit_led blink", 32'h3, {emit_led_o.bright, hi, lo});
        ilk_cmd <= 1'b1;
        wait_n(DEB + 12);
        chk("laser_emit_o", 32'h1, laser_emit_o);
        chk("emit_led_o", 32'h3, emit_led_o);
        key_cmd <= 1'b0;
        wait_n(DEB + 12);
        chk("src_pwr_en_o", 32'h0, src_pwr_en_o);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        key_cmd <= 1'b1;
        wait_n(DEB + 12);
        $display("test lock inputs done");

        wr(4'h0, 32'h5);
        @(negedge clk_i);
        chk("nvm_store_o", 32'h1, nvm_store_o);
        chk("nvm_data_o", 32'h5, nvm_data_o);
        wait_n(3);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        rd(4'h0, v);
        chk("ctrl", 32'h5, v);
        wr(4'h0, 32'h4);
        wait_n(4);
        chk("laser_emit_o", 32'h1, laser_emit_o);
        $display("test soft lock done");

        code = 8'($urandom_range(255));
        @(posedge clk_i);
        fault_i      <= 1'b1;
        fault_code_i <= code;
        @(negedge clk_i);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        @(posedge clk_i);
        fault_i <= 1'b0;
        wait_n(45);
        chk("status_led_o", 32'h4, status_led_o);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        rd(4'h2, v);
        chk("err code", {24'h0, code}, v);
        wr(4'h2, 32'h100);
        wait_n(4);
        chk("laser_emit_o", 32'h1, laser_emit_o);
        rd(4'hF, v);
        chk("unmapped", 32'h0, v);
        $display("test fault done");

        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_n(2);
        chk("status_led_o", 32'h6, status_led_o);
        wait_n(100);
        chk("laser_emit_o", 32'h0, laser_emit_o);
        rd(4'h1, v);
        chk("status", 32'h0B, v);
        $display("test second reset done");
        close_out;
    end

endmodule : tb
